// >>> usb_ep0_irq_pkg.sv
// Contract
// - Endpoint 0 access-enable bit 7 gates all buffer-manager service of that endpoint; setup_received still clears stall and sets both toggles while it is 0.
// - Read-only toggle bit 5 shows the next data packet PID, DATA0 or DATA1.
// - While stall bit 3 is set, every host access gets a STALL handshake.
// - Stall bit clears on the next setup packet, and by a software write.
// - IN endpoint 0 NAK bit 7 at 1 answers IN tokens with NAK.
// - OUT endpoint 0 NAK bit at 1 answers OUT tokens with NAK.
// - IN endpoint 0 count bits 6-0 give bytes sent per IN token.
// - OUT endpoint 0 count is a running total of bytes stored in the buffer.
// - All module interrupt requests merge through one arbiter into one CPU request.
// - Pending requests are served one at a time; lower code means higher priority.
// - Source field bits 7-0 show current code, 00h when none; 15-8 reserved.
// - Codes: OUT0 02h, IN0 04h, reset, suspend, resume, setup, overwrite, frame, pre-frame.
// - General endpoint codes are 10h+2n for OUT and 20h+2n for IN.
// - DMA codes 30h/31h/40h/41h plus 2n; host done 50h, host error 52h.
// - An endpoint flag sets whenever the buffer manager finishes moving that endpoint's data.
// - Endpoint flag clears on source read returning its code, or on write 1.
// - Endpoint request is raised only while flag and same-position enable are both 1.
// - GO flag clears on source read returning its code, or on write 1.
// - DMA completion with reload 1 clears reload and sets the reload flag.
// - One DMA enable bit per endpoint gates both GO and reload requests.
package usb_ep0_irq_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_IN_EP0_CONFIG = 8'h00;
	localparam logic [7:0] OFF_OUT_EP0_CONFIG = 8'h04;
	localparam logic [7:0] OFF_IN_EP0_BYTE_COUNT = 8'h08;
	localparam logic [7:0] OFF_OUT_EP0_BYTE_COUNT = 8'h0c;
	localparam logic [7:0] OFF_IRQ_SOURCE_CODE = 8'h10;
	localparam logic [7:0] OFF_OUT_ENDPOINT_FLAGS = 8'h14;
	localparam logic [7:0] OFF_IN_ENDPOINT_FLAGS = 8'h18;
	localparam logic [7:0] OFF_OUT_ENDPOINT_IRQ_ENABLES = 8'h1c;
	localparam logic [7:0] OFF_IN_ENDPOINT_IRQ_ENABLES = 8'h20;
	localparam logic [7:0] OFF_OUT_DMA_DONE_FLAGS = 8'h24;
	localparam logic [7:0] OFF_IN_DMA_DONE_FLAGS = 8'h28;
	localparam logic [7:0] OFF_OUT_DMA_RELOAD_FLAGS = 8'h2c;
	localparam logic [7:0] OFF_IN_DMA_RELOAD_FLAGS = 8'h30;
	localparam logic [7:0] OFF_OUT_DMA_IRQ_ENABLES = 8'h34;
	localparam logic [7:0] OFF_IN_DMA_IRQ_ENABLES = 8'h38;
	localparam logic [7:0] OFF_EVENT_FLAGS = 8'h3c;
	localparam logic [7:0] OFF_EVENT_IRQ_ENABLES = 8'h40;

	// Field positions
	localparam int ACCESS_ENABLE_BIT = 7;
	localparam int TOGGLE_BIT = 5;
	localparam int STALL_BIT = 3;
	localparam int NAK_BIT = 7;
	localparam int COUNT_W = 7;

	// Event flag layout
	localparam int EVT_BUS_RESET = 0;
	localparam int EVT_SUSPEND = 1;
	localparam int EVT_RESUME = 2;
	localparam int EVT_SETUP = 3;
	localparam int EVT_SETUP_OVERWRITE = 4;
	localparam int EVT_FRAME_START = 5;
	localparam int EVT_PRE_FRAME_START = 6;
	localparam int EVT_HOST_DONE = 7;
	localparam int EVT_HOST_ERROR = 8;
	localparam int NUM_EVENTS = 9;

	// Reset values
	localparam logic IN_NAK_RESET = 1'b1;
	localparam logic OUT_NAK_RESET = 1'b0;
	localparam logic [6:0] COUNT_RESET = 7'h00;
	localparam logic [7:0] SRC_NONE = 8'h00;

	// Arbiter slot layout, slot 0 is highest priority
	localparam int NUM_SOURCES = 53;
	localparam int SLOT_EVT = 2;
	localparam int SLOT_OUT_EP = 8;
	localparam int SLOT_IN_EP = 15;
	localparam int SLOT_OUT_DMA = 21;
	localparam int SLOT_IN_DMA = 35;
	localparam int SLOT_HOST_DONE = 51;
	localparam int SLOT_HOST_ERROR = 52;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		REPLY_DATA = 2'b01,
		REPLY_NAK = 2'b10,
		REPLY_STALL = 2'b11
	} reply_t;

	// Slot number to source code; slot order equals code order
	function automatic logic [7:0] source_code(input int slot);
		int c;
		if (slot == 0) begin
			c = 'h02;
		end else if (slot == 1) begin
			c = 'h04;
		end else if (slot < 8) begin
			c = 'h06 + 2 * (slot - 2);
		end else if (slot == 8) begin
			c = 'h11;
		end else if (slot < 16) begin
			c = 'h10 + 2 * (slot - SLOT_OUT_EP);
		end else if (slot < 23) begin
			c = 'h20 + 2 * (slot - SLOT_IN_EP);
		end else if (slot < 37) begin
			c = 'h32 + (slot - 23);
		end else if (slot < 51) begin
			c = 'h42 + (slot - 37);
		end else if (slot == SLOT_HOST_DONE) begin
			c = 'h50;
		end else begin
			c = 'h52;
		end
		return c[7:0];
	endfunction

endpackage

// >>> usb_ep0_and_interrupt_logic.sv
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module usb_ep0_and_interrupt_logic #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Buffer manager, endpoint 0
	input wire logic in_ep0_token,
	input wire logic out_ep0_token,
	input wire logic in_ep0_done,
	input wire logic out_ep0_done,
	input wire logic out_ep0_byte_stored,
	input wire logic setup_received,
	output usb_ep0_irq_pkg::reply_t in_ep0_reply,
	output logic in_ep0_reply_valid,
	output logic [6:0] in_ep0_send_count,
	output usb_ep0_irq_pkg::reply_t out_ep0_reply,
	output logic out_ep0_reply_valid,
	output logic in_ep0_toggle,
	output logic out_ep0_toggle,
	// General endpoints
	input wire logic [7:1] out_endpoint_done,
	input wire logic [7:1] in_endpoint_done,
	// Bus and host events
	input wire logic bus_reset_event,
	input wire logic suspend_event,
	input wire logic resume_event,
	input wire logic setup_overwrite_event,
	input wire logic frame_start_event,
	input wire logic pre_frame_start_event,
	input wire logic host_done_event,
	input wire logic host_error_event,
	// DMA controller
	input wire logic [7:1] dma_out_complete,
	input wire logic [7:1] dma_out_reload_request,
	input wire logic [7:1] dma_in_complete,
	input wire logic [7:1] dma_in_reload_request,
	output logic [7:1] dma_out_go_clear,
	output logic [7:1] dma_out_reload_clear,
	output logic [7:1] dma_in_go_clear,
	output logic [7:1] dma_in_reload_clear,
	// CPU request
	output logic cpu_irq
);

	// Endpoint 0 state
	logic in_enable, out_enable, in_stall, out_stall, in_nak, out_nak;
	logic [6:0] in_count, out_count;
	// Flags and enables
	logic [7:0] oep_flag, iep_flag, oep_ie, iep_ie;
	logic [7:1] odg, idg, odr, idr, odie, idie;
	logic [8:0] evt_flag, evt_ie;
	// Arbiter
	logic [7:0] src_code;
	logic [5:0] src_slot;
	logic src_valid;

	logic next_in_enable, next_out_enable, next_in_stall, next_out_stall;
	logic next_in_nak, next_out_nak, next_in_toggle, next_out_toggle;
	logic [6:0] next_in_count, next_out_count;
	logic [7:0] next_oep_flag, next_iep_flag, next_oep_ie, next_iep_ie;
	logic [7:1] next_odg, next_idg, next_odr, next_idr, next_odie, next_idie;
	logic [8:0] next_evt_flag, next_evt_ie;
	logic [7:0] next_src_code;
	logic [5:0] next_src_slot;
	logic next_src_valid, next_cpu_irq;
	logic next_awready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	usb_ep0_irq_pkg::reply_t next_in_reply, next_out_reply;
	logic next_in_reply_valid, next_out_reply_valid;
	logic [6:0] next_in_send_count;

	logic wr_en, rd_en;
	logic [15:0] wd;
	logic [7:0] waddr, raddr;
	logic [usb_ep0_irq_pkg::NUM_SOURCES-1:0] pend, rd_clr;
	logic [7:0] oep_rclr, iep_rclr;
	logic [7:1] odg_rclr, idg_rclr, odr_rclr, idr_rclr;
	logic [8:0] evt_rclr, evt_set;
	logic [31:0] rd_val;

	function automatic logic reg_hit(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= usb_ep0_irq_pkg::OFF_EVENT_IRQ_ENABLES);
	endfunction

	function automatic logic [7:0] w1c(input logic hit, input logic [7:0] d);
		return hit ? d : 8'h00;
	endfunction

	assign wr_en = awready & awvalid & wvalid;
	assign rd_en = arready & arvalid;
	assign waddr = 8'(awaddr);
	assign raddr = 8'(araddr);
	// Unstrobed lanes write nothing, so W1C bits there stay put
	assign wd = wdata[15:0] & {{8{wstrb[1]}}, {8{wstrb[0]}}};

	assign evt_set = {host_error_event, host_done_event, pre_frame_start_event,
		frame_start_event, setup_overwrite_event, setup_received, resume_event,
		suspend_event, bus_reset_event};

	// Slot map of request lines, each flag gated by its enable
	assign pend[0] = oep_flag[0] & oep_ie[0];
	assign pend[1] = iep_flag[0] & iep_ie[0];
	assign pend[8:2] = evt_flag[6:0] & evt_ie[6:0];
	assign pend[51] = evt_flag[7] & evt_ie[7];
	assign pend[52] = evt_flag[8] & evt_ie[8];
	assign oep_rclr[0] = rd_clr[0];
	assign iep_rclr[0] = rd_clr[1];
	assign evt_rclr = {rd_clr[52:51], rd_clr[8:2]};
	genvar n;
	generate
		for (n = 1; n < 8; n++) begin : g_ep
			assign pend[8 + n] = oep_flag[n] & oep_ie[n];
			assign pend[15 + n] = iep_flag[n] & iep_ie[n];
			assign pend[21 + 2 * n] = odr[n] & odie[n];
			assign pend[22 + 2 * n] = odg[n] & odie[n];
			assign pend[35 + 2 * n] = idr[n] & idie[n];
			assign pend[36 + 2 * n] = idg[n] & idie[n];
			assign oep_rclr[n] = rd_clr[8 + n];
			assign iep_rclr[n] = rd_clr[15 + n];
			assign odr_rclr[n] = rd_clr[21 + 2 * n];
			assign odg_rclr[n] = rd_clr[22 + 2 * n];
			assign idr_rclr[n] = rd_clr[35 + 2 * n];
			assign idg_rclr[n] = rd_clr[36 + 2 * n];
		end
	endgenerate

	// Read mux
	always_comb begin
		rd_val = 32'h0000_0000;
		case (raddr)
			usb_ep0_irq_pkg::OFF_IN_EP0_CONFIG: begin
				rd_val[7:0] = {in_enable, 1'b0, in_ep0_toggle, 1'b0, in_stall, 3'h0};
			end
			usb_ep0_irq_pkg::OFF_OUT_EP0_CONFIG: begin
				rd_val[7:0] = {out_enable, 1'b0, out_ep0_toggle, 1'b0, out_stall, 3'h0};
			end
			usb_ep0_irq_pkg::OFF_IN_EP0_BYTE_COUNT: rd_val[7:0] = {in_nak, in_count};
			usb_ep0_irq_pkg::OFF_OUT_EP0_BYTE_COUNT: rd_val[7:0] = {out_nak, out_count};
			usb_ep0_irq_pkg::OFF_IRQ_SOURCE_CODE: rd_val[7:0] = src_code;
			usb_ep0_irq_pkg::OFF_OUT_ENDPOINT_FLAGS: rd_val[7:0] = oep_flag;
			usb_ep0_irq_pkg::OFF_IN_ENDPOINT_FLAGS: rd_val[7:0] = iep_flag;
			usb_ep0_irq_pkg::OFF_OUT_ENDPOINT_IRQ_ENABLES: rd_val[7:0] = oep_ie;
			usb_ep0_irq_pkg::OFF_IN_ENDPOINT_IRQ_ENABLES: rd_val[7:0] = iep_ie;
			usb_ep0_irq_pkg::OFF_OUT_DMA_DONE_FLAGS: rd_val[7:0] = {odg, 1'b0};
			usb_ep0_irq_pkg::OFF_IN_DMA_DONE_FLAGS: rd_val[7:0] = {idg, 1'b0};
			usb_ep0_irq_pkg::OFF_OUT_DMA_RELOAD_FLAGS: rd_val[7:0] = {odr, 1'b0};
			usb_ep0_irq_pkg::OFF_IN_DMA_RELOAD_FLAGS: rd_val[7:0] = {idr, 1'b0};
			usb_ep0_irq_pkg::OFF_OUT_DMA_IRQ_ENABLES: rd_val[7:0] = {odie, 1'b0};
			usb_ep0_irq_pkg::OFF_IN_DMA_IRQ_ENABLES: rd_val[7:0] = {idie, 1'b0};
			usb_ep0_irq_pkg::OFF_EVENT_FLAGS: rd_val[8:0] = evt_flag;
			usb_ep0_irq_pkg::OFF_EVENT_IRQ_ENABLES: rd_val[8:0] = evt_ie;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Next state of the block, except the DMA clear outputs
	always_comb begin
		// Bus handshakes: one write and one read in flight at most
		next_awready = awvalid & wvalid & ~awready & ~bvalid;
		next_bvalid = bvalid ? ~bready : wr_en;
		next_bresp = wr_en ? (reg_hit(waddr) ? usb_ep0_irq_pkg::RESP_OKAY
			: usb_ep0_irq_pkg::RESP_SLVERR) : bresp;
		next_arready = arvalid & ~arready & ~rvalid;
		next_rvalid = rvalid ? ~rready : rd_en;
		next_rdata = rd_en ? rd_val : rdata;
		next_rresp = rd_en ? (reg_hit(raddr) ? usb_ep0_irq_pkg::RESP_OKAY
			: usb_ep0_irq_pkg::RESP_SLVERR) : rresp;

		// Reading the source clears exactly the slot whose code is returned
		rd_clr = '0;
		if (rd_en && raddr == usb_ep0_irq_pkg::OFF_IRQ_SOURCE_CODE && src_valid) begin
			rd_clr[src_slot] = 1'b1;
		end

		// Endpoint 0 descriptors
		next_in_enable = in_enable;
		next_out_enable = out_enable;
		next_in_stall = in_stall;
		next_out_stall = out_stall;
		next_in_nak = in_nak;
		next_out_nak = out_nak;
		next_in_count = in_count;
		next_out_count = out_count;
		next_in_toggle = in_ep0_toggle;
		next_out_toggle = out_ep0_toggle;
		if (wr_en && wstrb[0]) begin
			if (waddr == usb_ep0_irq_pkg::OFF_IN_EP0_CONFIG) begin
				next_in_enable = wdata[usb_ep0_irq_pkg::ACCESS_ENABLE_BIT];
				next_in_stall = wdata[usb_ep0_irq_pkg::STALL_BIT];
			end
			if (waddr == usb_ep0_irq_pkg::OFF_OUT_EP0_CONFIG) begin
				next_out_enable = wdata[usb_ep0_irq_pkg::ACCESS_ENABLE_BIT];
				next_out_stall = wdata[usb_ep0_irq_pkg::STALL_BIT];
			end
			// Loads above 64 are the writer's fault and are kept as written
			if (waddr == usb_ep0_irq_pkg::OFF_IN_EP0_BYTE_COUNT) begin
				next_in_nak = wdata[usb_ep0_irq_pkg::NAK_BIT];
				next_in_count = wdata[6:0];
			end
			if (waddr == usb_ep0_irq_pkg::OFF_OUT_EP0_BYTE_COUNT) begin
				next_out_nak = wdata[usb_ep0_irq_pkg::NAK_BIT];
				next_out_count = wdata[6:0];
			end
		end
		// Hardware updates come after the write so they win a same-cycle race
		if (out_enable && out_ep0_byte_stored && out_count != 7'h7f) begin
			next_out_count = out_count + 7'h01;
		end
		if (in_enable && in_ep0_done) begin
			next_in_nak = 1'b1;
			next_in_toggle = ~in_ep0_toggle;
		end
		if (out_enable && out_ep0_done) begin
			next_out_nak = 1'b1;
			next_out_toggle = ~out_ep0_toggle;
		end
		// Data stage after setup always opens with DATA1
		if (setup_received) begin
			next_in_stall = 1'b0;
			next_out_stall = 1'b0;
			next_in_toggle = 1'b1;
			next_out_toggle = 1'b1;
		end

		// Token answers; a disabled endpoint is never answered
		next_in_reply_valid = in_ep0_token & in_enable;
		next_out_reply_valid = out_ep0_token & out_enable;
		next_in_reply = in_stall ? usb_ep0_irq_pkg::REPLY_STALL
			: in_nak ? usb_ep0_irq_pkg::REPLY_NAK : usb_ep0_irq_pkg::REPLY_DATA;
		next_out_reply = out_stall ? usb_ep0_irq_pkg::REPLY_STALL
			: out_nak ? usb_ep0_irq_pkg::REPLY_NAK : usb_ep0_irq_pkg::REPLY_DATA;
		next_in_send_count = in_count;

		// Flags: set wins over both kinds of clear
		next_oep_flag = (oep_flag & ~oep_rclr
			& ~w1c(wr_en && waddr == usb_ep0_irq_pkg::OFF_OUT_ENDPOINT_FLAGS, wd[7:0]))
			| {out_endpoint_done, out_ep0_done & out_enable};
		next_iep_flag = (iep_flag & ~iep_rclr
			& ~w1c(wr_en && waddr == usb_ep0_irq_pkg::OFF_IN_ENDPOINT_FLAGS, wd[7:0]))
			| {in_endpoint_done, in_ep0_done & in_enable};
		next_odg = (odg & ~odg_rclr
			& ~7'(w1c(wr_en && waddr == usb_ep0_irq_pkg::OFF_OUT_DMA_DONE_FLAGS, wd[7:0]) >> 1))
			| (dma_out_complete & ~dma_out_reload_request);
		next_idg = (idg & ~idg_rclr
			& ~7'(w1c(wr_en && waddr == usb_ep0_irq_pkg::OFF_IN_DMA_DONE_FLAGS, wd[7:0]) >> 1))
			| (dma_in_complete & ~dma_in_reload_request);
		next_odr = (odr & ~odr_rclr
			& ~7'(w1c(wr_en && waddr == usb_ep0_irq_pkg::OFF_OUT_DMA_RELOAD_FLAGS, wd[7:0]) >> 1))
			| (dma_out_complete & dma_out_reload_request);
		next_idr = (idr & ~idr_rclr
			& ~7'(w1c(wr_en && waddr == usb_ep0_irq_pkg::OFF_IN_DMA_RELOAD_FLAGS, wd[7:0]) >> 1))
			| (dma_in_complete & dma_in_reload_request);
		next_evt_flag = (evt_flag & ~evt_rclr
			& ~(wr_en && waddr == usb_ep0_irq_pkg::OFF_EVENT_FLAGS ? wd[8:0] : 9'h000))
			| evt_set;

		// Enables
		next_oep_ie = oep_ie;
		next_iep_ie = iep_ie;
		next_odie = odie;
		next_idie = idie;
		next_evt_ie = evt_ie;
		if (wr_en && wstrb[0]) begin
			case (waddr)
				usb_ep0_irq_pkg::OFF_OUT_ENDPOINT_IRQ_ENABLES: next_oep_ie = wdata[7:0];
				usb_ep0_irq_pkg::OFF_IN_ENDPOINT_IRQ_ENABLES: next_iep_ie = wdata[7:0];
				usb_ep0_irq_pkg::OFF_OUT_DMA_IRQ_ENABLES: next_odie = wdata[7:1];
				usb_ep0_irq_pkg::OFF_IN_DMA_IRQ_ENABLES: next_idie = wdata[7:1];
				usb_ep0_irq_pkg::OFF_EVENT_IRQ_ENABLES: next_evt_ie[7:0] = wdata[7:0];
				default: next_oep_ie = oep_ie;
			endcase
		end
		if (wr_en && wstrb[1] && waddr == usb_ep0_irq_pkg::OFF_EVENT_IRQ_ENABLES) begin
			next_evt_ie[8] = wdata[8];
		end

		// Fixed-priority arbiter, lowest slot wins
		next_src_valid = 1'b0;
		next_src_slot = 6'h00;
		next_src_code = usb_ep0_irq_pkg::SRC_NONE;
		for (int i = usb_ep0_irq_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
			if (pend[i] && !rd_clr[i]) begin
				next_src_valid = 1'b1;
				next_src_slot = 6'(i);
				next_src_code = usb_ep0_irq_pkg::source_code(i);
			end
		end
		next_cpu_irq = next_src_valid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= usb_ep0_irq_pkg::RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= usb_ep0_irq_pkg::RESP_OKAY;
			in_enable <= 1'b0;
			out_enable <= 1'b0;
			in_stall <= 1'b0;
			out_stall <= 1'b0;
			in_nak <= usb_ep0_irq_pkg::IN_NAK_RESET;
			out_nak <= usb_ep0_irq_pkg::OUT_NAK_RESET;
			in_count <= usb_ep0_irq_pkg::COUNT_RESET;
			out_count <= usb_ep0_irq_pkg::COUNT_RESET;
			in_ep0_toggle <= 1'b0;
			out_ep0_toggle <= 1'b0;
			in_ep0_reply <= usb_ep0_irq_pkg::REPLY_NAK;
			out_ep0_reply <= usb_ep0_irq_pkg::REPLY_NAK;
			in_ep0_reply_valid <= 1'b0;
			out_ep0_reply_valid <= 1'b0;
			in_ep0_send_count <= usb_ep0_irq_pkg::COUNT_RESET;
			oep_flag <= 8'h00;
			iep_flag <= 8'h00;
			oep_ie <= 8'h00;
			iep_ie <= 8'h00;
			odg <= 7'h00;
			idg <= 7'h00;
			odr <= 7'h00;
			idr <= 7'h00;
			odie <= 7'h00;
			idie <= 7'h00;
			evt_flag <= 9'h000;
			evt_ie <= 9'h000;
			dma_out_go_clear <= 7'h00;
			dma_out_reload_clear <= 7'h00;
			dma_in_go_clear <= 7'h00;
			dma_in_reload_clear <= 7'h00;
			src_code <= usb_ep0_irq_pkg::SRC_NONE;
			src_slot <= 6'h00;
			src_valid <= 1'b0;
			cpu_irq <= 1'b0;
		end else begin
			awready <= next_awready;
			wready <= next_awready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			in_enable <= next_in_enable;
			out_enable <= next_out_enable;
			in_stall <= next_in_stall;
			out_stall <= next_out_stall;
			in_nak <= next_in_nak;
			out_nak <= next_out_nak;
			in_count <= next_in_count;
			out_count <= next_out_count;
			in_ep0_toggle <= next_in_toggle;
			out_ep0_toggle <= next_out_toggle;
			in_ep0_reply <= next_in_reply;
			out_ep0_reply <= next_out_reply;
			in_ep0_reply_valid <= next_in_reply_valid;
			out_ep0_reply_valid <= next_out_reply_valid;
			in_ep0_send_count <= next_in_send_count;
			oep_flag <= next_oep_flag;
			iep_flag <= next_iep_flag;
			oep_ie <= next_oep_ie;
			iep_ie <= next_iep_ie;
			odg <= next_odg;
			idg <= next_idg;
			odr <= next_odr;
			idr <= next_idr;
			odie <= next_odie;
			idie <= next_idie;
			evt_flag <= next_evt_flag;
			evt_ie <= next_evt_ie;
			dma_out_go_clear <= dma_out_complete & ~dma_out_reload_request;
			dma_out_reload_clear <= dma_out_complete & dma_out_reload_request;
			dma_in_go_clear <= dma_in_complete & ~dma_in_reload_request;
			dma_in_reload_clear <= dma_in_complete & dma_in_reload_request;
			src_code <= next_src_code;
			src_slot <= next_src_slot;
			src_valid <= next_src_valid;
			cpu_irq <= next_cpu_irq;
		end
	end

endmodule

// >>> usb_ep0_irq_properties.sv
`timescale 1ns/1ps
module usb_ep0_irq_properties #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshake
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// Endpoint 0
	input wire logic in_ep0_token,
	input wire logic out_ep0_token,
	input wire logic in_ep0_reply_valid,
	input wire logic out_ep0_reply_valid,
	// DMA
	input wire logic [7:1] dma_out_complete,
	input wire logic [7:1] dma_out_reload_request,
	input wire logic [7:1] dma_in_complete,
	input wire logic [7:1] dma_in_reload_request,
	input wire logic [7:1] dma_out_go_clear,
	input wire logic [7:1] dma_out_reload_clear,
	input wire logic [7:1] dma_in_go_clear,
	input wire logic [7:1] dma_in_reload_clear,
	// CPU
	input wire logic cpu_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_in_reply_cause: assert property (in_ep0_reply_valid |-> $past(in_ep0_token))
		else $error("in reply without token");
	a_out_reply_cause: assert property (out_ep0_reply_valid |-> $past(out_ep0_token))
		else $error("out reply without token");
	a_out_go_clear: assert property (dma_out_go_clear == $past(dma_out_complete & ~dma_out_reload_request))
		else $error("out go clear wrong");
	a_out_reload_clear: assert property (dma_out_reload_clear == $past(dma_out_complete & dma_out_reload_request))
		else $error("out reload clear wrong");
	a_in_go_clear: assert property (dma_in_go_clear == $past(dma_in_complete & ~dma_in_reload_request))
		else $error("in go clear wrong");
	a_in_reload_clear: assert property (dma_in_reload_clear == $past(dma_in_complete & dma_in_reload_request))
		else $error("in reload clear wrong");
	a_write_answer: assert property (awready |=> bvalid)
		else $error("write not answered");
	a_wready_pairs: assert property (wready == awready)
		else $error("write ready split");
	a_read_answer: assert property (arready |=> rvalid)
		else $error("read not answered");
	a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	c_reply: cover property (in_ep0_reply_valid);
	c_irq_drop: cover property ($fell(cpu_irq));
	c_reload: cover property (dma_out_reload_clear != 7'h00);
endmodule
bind usb_ep0_and_interrupt_logic usb_ep0_irq_properties #(.ADDR_W(ADDR_W)) i_props (.*);

// >>> usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
	// Clock
	input wire logic aclk,
	// Command: 1 IN token, 2 OUT token, 3 IN done, 4 OUT done, 5 byte, 6 setup
	input wire logic [2:0] op,
	// One-cycle pulses toward the endpoint logic
	output logic [5:0] pl
);
	logic [5:0] next_pl;
	always_comb begin
		next_pl = 6'h00;
		if (op != 3'h0) begin
			next_pl[op - 3'h1] = 1'b1;
		end
	end
	// Registered, so each pulse starts one edge after op and lasts as long as op is held
	always_ff @(posedge aclk) begin
		pl <= next_pl;
	end
endmodule

// >>> usb_ep0_and_interrupt_logic_tb.sv
`timescale 1ns/1ps
module usb_ep0_and_interrupt_logic_tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, cpu_irq, irv, orv;
	logic [7:0] awaddr, araddr, ev;
	logic [31:0] wdata, rdata, rv;
	logic [1:0] bresp, rresp, rs;
	logic [5:0] pl;
	logic [2:0] op;
	logic [6:0] isc, ic;
	logic [7:1] oed, ied, doc, dor, dic, dir;
	usb_ep0_irq_pkg::reply_t irr, orr, ir, orp;
	int err_total, checks_done, cyc_n, nrep, n0;
	usb_host_model i_usb_host_model (.aclk(aclk), .op(op), .pl(pl));
	usb_ep0_and_interrupt_logic i_usb_ep0_and_interrupt_logic (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .in_ep0_token(pl[0]), .out_ep0_token(pl[1]), .in_ep0_done(pl[2]),
		.out_ep0_done(pl[3]), .out_ep0_byte_stored(pl[4]), .setup_received(pl[5]),
		.in_ep0_reply(irr), .in_ep0_reply_valid(irv), .in_ep0_send_count(isc),
		.out_ep0_reply(orr), .out_ep0_reply_valid(orv), .in_ep0_toggle(), .out_ep0_toggle(),
		.out_endpoint_done(oed), .in_endpoint_done(ied), .bus_reset_event(ev[0]),
		.suspend_event(ev[1]), .resume_event(ev[2]), .setup_overwrite_event(ev[3]),
		.frame_start_event(ev[4]), .pre_frame_start_event(ev[5]), .host_done_event(ev[6]),
		.host_error_event(ev[7]), .dma_out_complete(doc), .dma_out_reload_request(dor),
		.dma_in_complete(dic), .dma_in_reload_request(dir), .dma_out_go_clear(),
		.dma_out_reload_clear(), .dma_in_go_clear(), .dma_in_reload_clear(), .cpu_irq(cpu_irq));
	task automatic complete_run;
		if (err_total == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
		cy(1);
	endtask
	task automatic r(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rv = rdata;
		rs = rresp;
		rready <= 1'b0;
		cy(1);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		r(a);
		ck($sformatf("reg %h", a), e, rv);
		ck("rresp", usb_ep0_irq_pkg::RESP_OKAY, rs);
	endtask
	// Reply lands three edges after the command
	task automatic tk(input logic [2:0] k);
		op <= k;
		cy(1);
		op <= 3'h0;
		cy(3);
	endtask
	always @(posedge aclk) begin
		cyc_n++;
		if (irv === 1'b1) begin
			ir <= irr;
			ic <= isc;
			nrep++;
		end
		if (orv === 1'b1) begin
			orp <= orr;
			nrep++;
		end
		if (cyc_n == 5000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{op, ev, oed, ied, doc, dor, dic, dir} = '0;
		cy(20);
		aresetn <= 1'b1;
		cy(1);
		rc(8'h00, 32'h00);
		rc(8'h08, 32'h80);
		rc(8'h0c, 32'h00);
		rc(8'h10, 32'h00);
		n0 = nrep;
		tk(3'h1);
		ck("reply count", n0, nrep);
		w(8'h00, 32'h88);
		tk(3'h1);
		ck("in reply", usb_ep0_irq_pkg::REPLY_STALL, ir);
		tk(3'h6);
		rc(8'h00, 32'ha0);
		w(8'h08, 32'h05);
		tk(3'h1);
		ck("in reply", usb_ep0_irq_pkg::REPLY_DATA, ir);
		ck("send count", 32'h05, ic);
		tk(3'h3);
		rc(8'h08, 32'h85);
		rc(8'h00, 32'h80);
		tk(3'h1);
		ck("in reply", usb_ep0_irq_pkg::REPLY_NAK, ir);
		w(8'h04, 32'h80);
		tk(3'h2);
		ck("out reply", usb_ep0_irq_pkg::REPLY_DATA, orp);
		repeat (3) tk(3'h5);
		rc(8'h0c, 32'h03);
		w(8'h0c, 32'h80);
		tk(3'h2);
		ck("out reply", usb_ep0_irq_pkg::REPLY_NAK, orp);
		tk(3'h4);
		rc(8'h10, 32'h00);
		w(8'h1c, 32'h01);
		w(8'h20, 32'h01);
		cy(2);
		ck("irq", 1, cpu_irq);
		rc(8'h10, 32'h02);
		rc(8'h10, 32'h04);
		rc(8'h10, 32'h00);
		ck("irq", 0, cpu_irq);
		ied <= 7'h40;
		cy(1);
		ied <= 7'h00;
		w(8'h20, 32'h81);
		rc(8'h10, 32'h2e);
		rc(8'h18, 32'h00);
		ied <= 7'h40;
		cy(1);
		ied <= 7'h00;
		rc(8'h18, 32'h80);
		w(8'h18, 32'h80);
		rc(8'h18, 32'h00);
		rc(8'h10, 32'h00);
		w(8'h34, 32'h02);
		dor <= 7'h01;
		doc <= 7'h01;
		cy(1);
		dor <= 7'h00;
		cy(1);
		doc <= 7'h00;
		cy(3);
		rc(8'h10, 32'h32);
		rc(8'h10, 32'h33);
		rc(8'h10, 32'h00);
		dic <= 7'h40;
		cy(1);
		dic <= 7'h00;
		cy(3);
		rc(8'h10, 32'h00);
		w(8'h38, 32'h80);
		rc(8'h10, 32'h4f);
		w(8'h40, 32'h1ff);
		ev <= 8'hc1;
		cy(1);
		ev <= 8'h00;
		cy(3);
		rc(8'h10, 32'h06);
		rc(8'h10, 32'h0c);
		rc(8'h10, 32'h50);
		rc(8'h10, 32'h52);
		r(8'h44);
		ck("rresp", usb_ep0_irq_pkg::RESP_SLVERR, rs);
		ck("rdata", 0, rv);
		w(8'h44, 32'h01);
		ck("bresp", usb_ep0_irq_pkg::RESP_SLVERR, rs);
		aresetn <= 1'b0;
		cy(2);
		aresetn <= 1'b1;
		cy(1);
		rc(8'h00, 32'h00);
		rc(8'h40, 32'h00);
		complete_run();
	end
endmodule
